// >>> mtc_pkg.sv
/*
 * mtc_pkg: shared constants, enumerations and carrier structs of the
 * multimode 16-bit timer with two reload/capture registers.
 * assumes: a single 200 MHz clock; software reaches the registers over a
 * plain address/strobe port with read data one cycle after the strobe.
 */
package mtc_pkg;
   localparam int MTC_WIDTH = 16;
   localparam int MTC_ADDR_W = 4;
   localparam int MTC_DATA_W = 16;

   // ***************************************************
   // register offsets (word index on the plain port)
   // ***************************************************
   localparam logic [3:0] MTC_OFF_CTRL = 4'h0;
   localparam logic [3:0] MTC_OFF_IRQ = 4'h1;
   localparam logic [3:0] MTC_OFF_RELA = 4'h2;
   localparam logic [3:0] MTC_OFF_RELB = 4'h3;
   localparam logic [3:0] MTC_OFF_COUNT = 4'h4;

   // ***************************************************
   // field positions
   // ***************************************************
   // control: [3:1] mode select, [0] run / underflow flag
   localparam int MTC_CTRL_RUN = 0;
   localparam int MTC_CTRL_MODE_LO = 1;
   localparam int MTC_CTRL_MODE_HI = 3;
   // irq register: [0] pend_a [1] pend_b [2] irq_en_a [3] irq_en_b
   localparam int MTC_IRQ_PEND_A = 0;
   localparam int MTC_IRQ_PEND_B = 1;
   localparam int MTC_IRQ_EN_A = 2;
   localparam int MTC_IRQ_EN_B = 3;

   localparam logic [2:0] MTC_MODE_RESET = 3'h0;
   localparam logic [15:0] MTC_COUNT_RESET = 16'h0000;
   localparam logic [15:0] MTC_ZERO16 = 16'h0000;

   // ***************************************************
   // modes
   // ***************************************************
   typedef enum logic [2:0] {
      MTC_M_PWM_TOG,
      MTC_M_PWM_NOTOG,
      MTC_M_EVENT,
      MTC_M_CAP_RR,
      MTC_M_CAP_RF,
      MTC_M_CAP_FF
   } mtc_mode_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } mtc_edge_t;

   typedef struct packed {
      logic [MTC_ADDR_W-1:0] addr;
      logic [MTC_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } mtc_bus_req_t;

   typedef struct packed {
      logic pinAOut;
      logic pinAOeN;
      logic irqA;
      logic irqB;
   } mtc_pins_out_t;
endpackage

// >>> mtc_edge_sync.sv
/*
 * mtc_edge_sync: two-stage synchroniser of one pin with edge detection.
 * assumes: pin may be asynchronous; output edges are one-cycle pulses.
 */
`timescale 1ns/1ps
module mtc_edge_sync
   import mtc_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic resetn, // synchronous reset, active low
   input wire logic pin, // raw pin level
   output mtc_pkg::mtc_edge_t edges // one-cycle edge pulses
);
   import mtc_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } mtc_sync_st_t;

   mtc_sync_st_t st_q;
   mtc_sync_st_t st_d;

   always_comb
   begin
      st_d.s1 = pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // edges come from the second and third stages only, never the first
   assign edges.rise = st_q.s2 & ~st_q.s3;
   assign edges.fall = ~st_q.s2 & st_q.s3;
endmodule

// >>> mtc_timer.sv
/*
 * mtc_timer: 16-bit down counter with two reload/capture registers, run in
 * PWM, external event counting or dual-edge input capture mode.
 * assumes: one clock at the instruction-cycle rate; pins A and B come from
 * outside; the host register port never waits.
 */
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - event mode counts chosen pin A edges instead of the clock.
// - event mode: underflow sets pend_a; interrupt if irq_en_a.
// - event mode: pin B rising edge sets pend_b; interrupt if irq_en_b.
// - event mode never drives a waveform on pin A.
// - capture mode counts every cycle regardless of pins.
// - capture copies the count into register A or B on trigger edges.
// - pin A and pin B trigger polarities come together from the mode: rise/rise, rise/fall or fall/fall.
// - capture edges set pend_a and pend_b; interrupts if irq_en_a and irq_en_b.
// - capture underflow sets the run bit; interrupt A if irq_en_a.
// - in PWM and event modes the run bit starts and stops the count.
// - enables gate requests only; pending flags latch regardless.
// - PWM counts down, first reload from A, then alternates B and A.
// - PWM toggling mode inverts pin A on every underflow.
module mtc_timer
   import mtc_pkg::*;
#(
   parameter int WIDTH = MTC_WIDTH
)
(
   input wire logic clk, // 200 MHz clock
   input wire logic resetn, // synchronous reset, active low
   input mtc_pkg::mtc_bus_req_t busReq, // register port request
   output logic [MTC_DATA_W-1:0] rdata, // read data, cycle after rd
   input wire logic timerPinAIn, // pin A input level
   input wire logic timerPinBIn, // pin B input level
   output mtc_pkg::mtc_pins_out_t pinsOut // pin A drive and interrupt requests
);
   import mtc_pkg::*;

   // the register port is one word wide, so the counter must match it
   if (WIDTH != MTC_DATA_W)
   begin : g_width_check
      $error("mtc_timer: WIDTH must equal register data width");
   end

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [WIDTH-1:0] mainTimer;
      logic [WIDTH-1:0] reloadCaptureA;
      logic [WIDTH-1:0] reloadCaptureB;
      logic [2:0] modeSel;
      logic runOrUnderflowFlag;
      logic pendA;
      logic pendB;
      logic irqEnA;
      logic irqEnB;
      logic nextFromB;
      logic pinA;
      logic pinAOeN;
      logic irqA;
      logic irqB;
      logic [MTC_DATA_W-1:0] rdata;
   } mtc_state_t;

   mtc_state_t st_q;
   mtc_state_t st_d;

   mtc_edge_t edgeA;
   mtc_edge_t edgeB;

   mtc_edge_sync u_sync_a (
      .clk(clk),
      .resetn(resetn),
      .pin(timerPinAIn),
      .edges(edgeA)
   );

   mtc_edge_sync u_sync_b (
      .clk(clk),
      .resetn(resetn),
      .pin(timerPinBIn),
      .edges(edgeB)
   );

   // ***************************************************
   // mode decode
   // ***************************************************
   function automatic mtc_mode_t decode_mode(input logic [2:0] m);
      case (m)
         3'h5: decode_mode = MTC_M_PWM_TOG;
         3'h4: decode_mode = MTC_M_PWM_NOTOG;
         3'h0, 3'h1: decode_mode = MTC_M_EVENT;
         3'h2: decode_mode = MTC_M_CAP_RR;
         3'h6: decode_mode = MTC_M_CAP_RF;
         default: decode_mode = MTC_M_CAP_FF;
      endcase
   endfunction

   function automatic logic is_capture(input mtc_mode_t md);
      is_capture = (md == MTC_M_CAP_RR) || (md == MTC_M_CAP_RF) || (md == MTC_M_CAP_FF);
   endfunction

   mtc_mode_t mode;
   logic capMode;
   logic tick;
   logic underflow;
   logic trigA;
   logic trigB;
   logic wrCtrl;
   logic wrIrq;
   logic [MTC_DATA_W-1:0] wd;

   always_comb
   begin
      mode = decode_mode(st_q.modeSel);
      capMode = is_capture(mode);
      wd = busReq.wdata;
      wrCtrl = busReq.wr && (busReq.addr == MTC_OFF_CTRL);
      wrIrq = busReq.wr && (busReq.addr == MTC_OFF_IRQ);
      // count source per mode
      case (mode)
         MTC_M_EVENT:
         begin
            // 000 counts rising pin A edges, 001 falling
            tick = st_q.runOrUnderflowFlag
                   && (st_q.modeSel[0] ? edgeA.fall : edgeA.rise);
         end
         MTC_M_CAP_RR, MTC_M_CAP_RF, MTC_M_CAP_FF:
         begin
            tick = 1'b1;
         end
         default:
         begin
            tick = st_q.runOrUnderflowFlag;
         end
      endcase
      underflow = tick && (st_q.mainTimer == MTC_ZERO16);
      // capture triggers, polarity per pin
      trigA = (mode == MTC_M_CAP_FF) ? edgeA.fall : edgeA.rise;
      trigB = (mode == MTC_M_CAP_RR) ? edgeB.rise : edgeB.fall;
      trigA = trigA && capMode;
      trigB = trigB && capMode;
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb
   begin
      st_d = st_q;
      st_d.rdata = '0;

      // software writes first; hardware sets below override clears
      if (wrCtrl)
      begin
         st_d.modeSel = wd[MTC_CTRL_MODE_HI:MTC_CTRL_MODE_LO];
         st_d.runOrUnderflowFlag = wd[MTC_CTRL_RUN];
         if (!wd[MTC_CTRL_RUN])
         begin
            // a fresh start reloads from A first
            st_d.nextFromB = 1'b0;
         end
      end
      if (wrIrq)
      begin
         st_d.pendA = wd[MTC_IRQ_PEND_A];
         st_d.pendB = wd[MTC_IRQ_PEND_B];
         st_d.irqEnA = wd[MTC_IRQ_EN_A];
         st_d.irqEnB = wd[MTC_IRQ_EN_B];
      end
      if (busReq.wr && (busReq.addr == MTC_OFF_RELA))
      begin
         st_d.reloadCaptureA = wd;
      end
      if (busReq.wr && (busReq.addr == MTC_OFF_RELB))
      begin
         st_d.reloadCaptureB = wd;
      end
      if (busReq.wr && (busReq.addr == MTC_OFF_COUNT))
      begin
         st_d.mainTimer = wd;
      end

      // counting
      if (tick)
      begin
         st_d.mainTimer = st_q.mainTimer - 16'h0001;
      end

      case (mode)
         MTC_M_PWM_TOG, MTC_M_PWM_NOTOG:
         begin
            if (underflow)
            begin
               // alternate reloads, each latching its own pending flag
               if (st_q.nextFromB)
               begin
                  st_d.mainTimer = st_q.reloadCaptureB;
                  st_d.pendB = 1'b1;
               end
               else
               begin
                  st_d.mainTimer = st_q.reloadCaptureA;
                  st_d.pendA = 1'b1;
               end
               st_d.nextFromB = ~st_q.nextFromB;
               if (mode == MTC_M_PWM_TOG)
               begin
                  st_d.pinA = ~st_q.pinA;
               end
            end
         end
         MTC_M_EVENT:
         begin
            if (underflow)
            begin
               st_d.mainTimer = st_q.reloadCaptureA;
               st_d.pendA = 1'b1;
            end
            if (edgeB.rise)
            begin
               st_d.pendB = 1'b1;
            end
         end
         MTC_M_CAP_RR, MTC_M_CAP_RF, MTC_M_CAP_FF:
         begin
            // counter wraps freely in capture mode
            if (underflow)
            begin
               st_d.runOrUnderflowFlag = 1'b1;
            end
            if (trigA)
            begin
               st_d.reloadCaptureA = st_q.mainTimer;
               st_d.pendA = 1'b1;
            end
            if (trigB)
            begin
               st_d.reloadCaptureB = st_q.mainTimer;
               st_d.pendB = 1'b1;
            end
         end
         default:
         begin
            st_d.nextFromB = st_q.nextFromB;
         end
      endcase

      // pin A is driven only in PWM toggling mode
      st_d.pinAOeN = (decode_mode(st_d.modeSel) != MTC_M_PWM_TOG);

      // requests gated by enables, flags latch regardless
      st_d.irqA = st_d.irqEnA && (st_d.pendA
                  || (is_capture(decode_mode(st_d.modeSel))
                      && st_d.runOrUnderflowFlag));
      st_d.irqB = st_d.irqEnB && st_d.pendB;

      // ***************************************************
      // read port
      // ***************************************************
      if (busReq.rd)
      begin
         case (busReq.addr)
            MTC_OFF_CTRL:
            begin
               st_d.rdata[MTC_CTRL_MODE_HI:MTC_CTRL_MODE_LO] = st_q.modeSel;
               st_d.rdata[MTC_CTRL_RUN] = st_q.runOrUnderflowFlag;
            end
            MTC_OFF_IRQ:
            begin
               st_d.rdata[MTC_IRQ_PEND_A] = st_q.pendA;
               st_d.rdata[MTC_IRQ_PEND_B] = st_q.pendB;
               st_d.rdata[MTC_IRQ_EN_A] = st_q.irqEnA;
               st_d.rdata[MTC_IRQ_EN_B] = st_q.irqEnB;
            end
            MTC_OFF_RELA: st_d.rdata = st_q.reloadCaptureA;
            MTC_OFF_RELB: st_d.rdata = st_q.reloadCaptureB;
            MTC_OFF_COUNT: st_d.rdata = st_q.mainTimer;
            default: st_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st_q <= '0;
         st_q.modeSel <= MTC_MODE_RESET;
         st_q.mainTimer <= MTC_COUNT_RESET;
         st_q.pinAOeN <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign pinsOut.pinAOut = st_q.pinA;
   assign pinsOut.pinAOeN = st_q.pinAOeN;
   assign pinsOut.irqA = st_q.irqA;
   assign pinsOut.irqB = st_q.irqB;
endmodule

// >>> mtc_timer_properties.sv
/*
 * mtc_timer_chk: concurrent checks on the ports of mtc_timer, bound below.
 * assumes: mode and enable bits change only through the host port; one clock domain.
 */
`timescale 1ns/1ps
module mtc_timer_chk
   import mtc_pkg::*;
(
   input wire logic clk, // clock
   input wire logic resetn, // sync reset, active low
   input mtc_pkg::mtc_bus_req_t busReq, // register port request
   input wire logic [mtc_pkg::MTC_DATA_W-1:0] rdata, // read data
   input wire logic timerPinAIn, // pin A level
   input wire logic timerPinBIn, // pin B level
   input mtc_pkg::mtc_pins_out_t pinsOut // pin drive and requests
);
   // ***************************
   // shadow of software writes
   // ***************************
   logic [2:0] modeQ;
   logic runQ;
   logic enAQ;
   logic enBQ;
   logic relOkQ;
   logic [15:0] relAQ;
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         {modeQ, runQ, enAQ, enBQ, relOkQ} <= 7'h00;
         relAQ <= 16'h0000;
      end
      else
      begin
         // capture mode may overwrite register A behind our back
         if (modeQ[1])
            relOkQ <= 1'b0;
         if (busReq.wr && busReq.addr == MTC_OFF_CTRL)
            {modeQ, runQ} <= busReq.wdata[3:0];
         if (busReq.wr && busReq.addr == MTC_OFF_IRQ)
            {enBQ, enAQ} <= busReq.wdata[3:2];
         if (busReq.wr && busReq.addr == MTC_OFF_RELA)
         begin
            relAQ <= busReq.wdata;
            relOkQ <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_evt;
      !modeQ[2] && !modeQ[1];
   endsequence
   sequence s_pwmStop;
      modeQ[2:1] == 2'b10 && !runQ;
   endsequence
   property p_rdIdle;
      !busReq.rd |=> rdata == 16'h0000;
   endproperty
   property p_relRead;
      busReq.rd && busReq.addr == MTC_OFF_RELA && relOkQ && !modeQ[1] |=> rdata == relAQ;
   endproperty
   property p_oeEvent;
      s_evt ##1 s_evt |-> pinsOut.pinAOeN;
   endproperty
   property p_irqAEn;
      pinsOut.irqA |-> enAQ;
   endproperty
   property p_irqBEn;
      pinsOut.irqB |-> enBQ;
   endproperty
   property p_stopHold;
      s_pwmStop ##1 s_pwmStop |-> $stable(pinsOut.pinAOut);
   endproperty
   property p_evtB;
      !modeQ[2] && !modeQ[1] && enBQ && $rose(timerPinBIn) |-> ##[1:6] pinsOut.irqB;
   endproperty
   property p_capB;
      modeQ == 3'h6 && enBQ && $fell(timerPinBIn) |-> ##[1:6] pinsOut.irqB;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
   a_relRead: assert property (p_relRead) else $error("reload A readback");
   a_oeEvent: assert property (p_oeEvent) else $error("pin A driven");
   a_irqAEn: assert property (p_irqAEn) else $error("request A ungated");
   a_irqBEn: assert property (p_irqBEn) else $error("request B ungated");
   a_stopHold: assert property (p_stopHold) else $error("stopped pin moved");
   a_evtB: assert property (p_evtB) else $error("pin B edge lost");
   a_capB: assert property (p_capB) else $error("capture B lost");
endmodule
bind mtc_timer mtc_timer_chk u_chk (.clk(clk), .resetn(resetn), .busReq(busReq),
   .rdata(rdata), .timerPinAIn(timerPinAIn), .timerPinBIn(timerPinBIn),
   .pinsOut(pinsOut));

// >>> mtc_pin_src.sv
/*
 * mtc_pin_src: outside pulse source on the two timer pins.
 * assumes: called from the bench; pins idle low.
 */
`timescale 1ns/1ps
module mtc_pin_src
(
   input wire logic clk, // clock
   output logic pinA, // level onto pin A
   output logic pinB // level onto pin B
);
   // ***************************
   // pin drive
   // ***************************
   initial
   begin
      pinA = 1'b0;
      pinB = 1'b0;
   end
   // short holds model a prompt source, long holds a slow one
   task automatic setPin(input logic b, input logic v, input int hold);
      @(posedge clk);
      if (b)
         pinB <= v;
      else
         pinA <= v;
      repeat (hold) @(posedge clk);
   endtask
   task automatic pulse(input logic b, input int n, input int hold);
      repeat (n)
      begin
         setPin(b, 1'b1, hold);
         setPin(b, 1'b0, hold);
      end
   endtask
endmodule

// >>> tb.sv
/*
 * tb: self-checking bench of mtc_timer.
 * assumes: mtc_pin_src drives the pins; checker is bound to the timer.
 */
`timescale 1ns/1ps
module tb;
   import mtc_pkg::*;
   // ***************************
   // bench
   // ***************************
   logic clk;
   logic resetn;
   mtc_bus_req_t busReq;
   logic [15:0] rdata;
   logic pinA;
   logic pinB;
   mtc_pins_out_t pinsOut;
   int miscompares = 0;
   int n_compared = 0;
   logic [15:0] v1;
   logic [15:0] v2;
   int n;
   mtc_timer u_mtc_timer (.clk(clk), .resetn(resetn), .busReq(busReq), .rdata(rdata),
      .timerPinAIn(pinA), .timerPinBIn(pinB), .pinsOut(pinsOut));
   mtc_pin_src u_mtc_pin_src (.clk(clk), .pinA(pinA), .pinB(pinB));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic results;
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdChk(input string nm, input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(nm, d, exp);
   endtask
   // cycles until pin A changes, bounded
   task automatic waitTog(output int k);
      logic p;
      #1;
      p = pinsOut.pinAOut;
      k = 0;
      while (pinsOut.pinAOut === p && k < 50)
      begin
         @(posedge clk);
         #1 k++;
      end
   endtask
   task automatic tReset;
      wr(4'hF, 16'hFFFF);
      rdChk("unmapped", 4'hF, 16'h0000);
      rdChk("ctrl", MTC_OFF_CTRL, 16'h0000);
      rdChk("irq", MTC_OFF_IRQ, 16'h0000);
      rdChk("count", MTC_OFF_COUNT, 16'h0000);
   endtask
   task automatic tPwm;
      wr(MTC_OFF_RELA, 16'h0003);
      wr(MTC_OFF_RELB, 16'h0005);
      wr(MTC_OFF_IRQ, 16'h000C);
      wr(MTC_OFF_CTRL, 16'h000B);
      waitTog(n);
      chk("oeN", 16'(pinsOut.pinAOeN), 16'h0000);
      waitTog(n);
      chk("high", 16'(n), 16'h0004);
      waitTog(n);
      chk("low", 16'(n), 16'h0006);
      rdChk("pend", MTC_OFF_IRQ, 16'h000F);
      wr(MTC_OFF_CTRL, 16'h000A);
      rd(MTC_OFF_COUNT, v1);
      repeat (10) @(posedge clk);
      rd(MTC_OFF_COUNT, v2);
      chk("stop", v2, v1);
      rdChk("relA", MTC_OFF_RELA, 16'h0003);
      rdChk("held", MTC_OFF_IRQ, 16'h000F);
      wr(MTC_OFF_IRQ, 16'h000C);
      rdChk("clear", MTC_OFF_IRQ, 16'h000C);
   endtask
   task automatic tNoTog;
      wr(MTC_OFF_CTRL, 16'h0009);
      repeat (20) @(posedge clk);
      #1 chk("noTog", 16'(pinsOut.pinAOut), 16'h0000);
      chk("noTogOe", 16'(pinsOut.pinAOeN), 16'h0001);
      rdChk("noTogPend", MTC_OFF_IRQ, 16'h000F);
      wr(MTC_OFF_CTRL, 16'h0008);
      wr(MTC_OFF_IRQ, 16'h000C);
   endtask
   task automatic tEvent;
      wr(MTC_OFF_RELA, 16'h0002);
      wr(MTC_OFF_COUNT, 16'h0001);
      wr(MTC_OFF_IRQ, 16'h0008);
      wr(MTC_OFF_CTRL, 16'h0001);
      repeat (8) @(posedge clk);
      rdChk("idle", MTC_OFF_COUNT, 16'h0001);
      u_mtc_pin_src.pulse(1'b0, 2, 4);
      rdChk("evt", MTC_OFF_COUNT, 16'h0002);
      chk("irqA", 16'(pinsOut.irqA), 16'h0000);
      u_mtc_pin_src.pulse(1'b1, 1, 4);
      rdChk("pend", MTC_OFF_IRQ, 16'h000B);
      chk("irqB", 16'(pinsOut.irqB), 16'h0001);
      chk("oeN", 16'(pinsOut.pinAOeN), 16'h0001);
      wr(MTC_OFF_IRQ, 16'h000F);
      #1 chk("irqA", 16'(pinsOut.irqA), 16'h0001);
      wr(MTC_OFF_CTRL, 16'h0003);
      u_mtc_pin_src.pulse(1'b0, 1, 12);
      rdChk("fall", MTC_OFF_COUNT, 16'h0001);
   endtask
   task automatic tCapture;
      wr(MTC_OFF_IRQ, 16'h000C);
      wr(MTC_OFF_COUNT, 16'h0100);
      wr(MTC_OFF_CTRL, 16'h000C);
      rd(MTC_OFF_COUNT, v1);
      rd(MTC_OFF_COUNT, v2);
      chk("free", v1 - v2, 16'h0002);
      u_mtc_pin_src.setPin(1'b1, 1'b1, 8);
      rdChk("riseB", MTC_OFF_IRQ, 16'h000C);
      u_mtc_pin_src.setPin(1'b1, 1'b0, 8);
      rdChk("fallB", MTC_OFF_IRQ, 16'h000E);
      rd(MTC_OFF_RELB, v1);
      chk("capB", 16'(v1 < 16'h0100 && v1 > 16'h0080), 16'h0001);
      u_mtc_pin_src.setPin(1'b0, 1'b1, 8);
      rdChk("riseA", MTC_OFF_IRQ, 16'h000F);
      rd(MTC_OFF_RELA, v2);
      chk("capA", 16'(v2 < v1), 16'h0001);
      wr(MTC_OFF_IRQ, 16'h0004);
      // the free-running count ignores writes, so load it while stopped
      wr(MTC_OFF_CTRL, 16'h0000);
      wr(MTC_OFF_COUNT, 16'h0004);
      wr(MTC_OFF_CTRL, 16'h000C);
      repeat (10) @(posedge clk);
      rdChk("uflow", MTC_OFF_CTRL, 16'h000D);
      chk("irqA", 16'(pinsOut.irqA), 16'h0001);
      rdChk("uflowPend", MTC_OFF_IRQ, 16'h0004);
      wr(MTC_OFF_CTRL, 16'h0004);
      wr(MTC_OFF_IRQ, 16'h000C);
      u_mtc_pin_src.setPin(1'b1, 1'b1, 8);
      rdChk("riseRR", MTC_OFF_IRQ, 16'h000E);
      wr(MTC_OFF_CTRL, 16'h0006);
      u_mtc_pin_src.setPin(1'b0, 1'b0, 8);
      rdChk("fallFF", MTC_OFF_IRQ, 16'h000F);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results;
   end
   initial
   begin
      resetn = 1'b0;
      busReq = '0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      tReset;
      tPwm;
      tNoTog;
      tEvent;
      tCapture;
      results;
   end
endmodule
